// file: eipc_pkg.sv
// constants and carrier types shared by the external interrupt pin controller
package eipc_pkg;

   localparam int          EIPC_NUM_PINS    = 3;
   localparam int          EIPC_ADDR_W      = 16;
   localparam int          EIPC_SYNC_STAGES = 2;

   localparam logic [15:0] EIPC_OFS_A       = 16'h1017;
   localparam logic [15:0] EIPC_OFS_B       = 16'h1018;
   localparam logic [15:0] EIPC_OFS_C       = 16'h1019;

   localparam int          EIPC_FLAG_BIT    = 7;
   localparam int          EIPC_LEVEL_BIT   = 6;
   localparam int          EIPC_DIR_BIT     = 4;
   localparam int          EIPC_DOUT_BIT    = 3;
   localparam int          EIPC_POL_BIT     = 2;
   localparam int          EIPC_PRI_BIT     = 1;
   localparam int          EIPC_EN_BIT      = 0;

   localparam logic [7:0]  EIPC_CTRL_RESET  = 8'h00;

   // per-pin control bits
   typedef struct packed {
      logic edge_seen_flag;
      logic pin_direction;
      logic pin_drive_value;
      logic edge_select;
      logic level_select;
      logic line_enable;
   } eipc_ctl_s;

   localparam eipc_ctl_s EIPC_CTL_RESET = '0;

   // peripheral file access from the core
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [7:0]  wdata;
   } eipc_pf_req_s;

   // system-level controls that live outside this block
   typedef struct packed {
      logic nonmaskable_select;
      logic hard_watchdog;
      logic halt_mode;
      logic standby_mode;
      logic high_level_global_enable;
      logic low_level_global_enable;
   } eipc_sys_s;

   // synchroniser and edge history of one pin
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
   } eipc_sync_s;

   // registered state of the controller, apart from the pin synchronisers
   typedef struct packed {
      eipc_ctl_s [2:0] ctl;
      logic [7:0]      rdata;
      logic            level_one_req;
      logic            level_two_req;
      logic            nmi_req;
      logic            wake_req;
      logic [1:0]      gp_out;
      logic [1:0]      gp_oe_n;
   } eipc_state_s;

endpackage : eipc_pkg

// file: eipc_pin_sync.sv
// two-stage pin synchroniser with edge detection on the synchronised level
module eipc_pin_sync
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic pin_i,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   eipc_pkg::eipc_sync_s st_q;
   eipc_pkg::eipc_sync_s st_d;

   always_comb
   begin
      st_d      = st_q;
      st_d.s1   = pin_i;
      st_d.s2   = st_q.s1;
      st_d.prev = st_q.s2;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q <= '0;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign level = st_q.s2;
   assign rise  = st_q.s2 & ~st_q.prev;
   assign fall  = ~st_q.s2 & st_q.prev;

   sync_delay_a : assert property (@(posedge sys_clk) disable iff (rst)
      $rose(st_q.s2) |-> $past(pin_i, 2))
      else $error("pin level rose without a pin high two cycles earlier");

endmodule : eipc_pin_sync

// file: eipc_ctrl.sv
// external interrupt pin controller: three pins, control registers, requests
//
// Overview of operation
// - edge_select 1 rising, 0 falling trigger
// - selected edge sets flag even when disabled
// - flag sticky, software clear only, resets 0
// - request held while flag set and enabled
// - forward needs line_enable and matching global enable
// - level_select 1 level two, 0 level one
// - nonmaskable first pin ignores enables and level
// - nonmaskable first pin never sets its flag
// - nonmaskable request on every selected first pin edge
// - low power with hard watchdog forces nonmaskable
// - pin_level reads synchronised pin, resets 0
// - reserved bits read 0
// - pin_direction 1 output, 0 input pin
// - output pin driven from pin_drive_value
// - first pin is input only
// - pins wake from halt or standby; halt uses level
// - reset clears every defined control bit
// - three byte registers at consecutive addresses
// - pin passes two synchroniser flops first
module eipc_ctrl
(
   input  wire logic                  sys_clk,
   input  wire logic                  rst,
   input  wire eipc_pkg::eipc_pf_req_s pf_req,
   output logic [7:0]                 pf_rdata,
   input  wire eipc_pkg::eipc_sys_s   sys_ctl,
   input  wire logic                  ext_irq_a_pin,
   input  wire logic                  ext_irq_b_pin_i,
   output logic                       ext_irq_b_pin_o,
   output logic                       ext_irq_b_pin_oe_n,
   input  wire logic                  ext_irq_c_pin_i,
   output logic                       ext_irq_c_pin_o,
   output logic                       ext_irq_c_pin_oe_n,
   output logic                       level_one_req,
   output logic                       level_two_req,
   output logic                       nmi_req,
   output logic                       wake_req
);

   eipc_pkg::eipc_state_s st_q;
   eipc_pkg::eipc_state_s st_d;

   logic [2:0] pin_lvl;
   logic [2:0] pin_rise;
   logic [2:0] pin_fall;
   logic [2:0] pin_raw;
   logic [2:0] ev;
   logic       low_power;
   logic       nmi_mode;

   assign pin_raw = {ext_irq_c_pin_i, ext_irq_b_pin_i, ext_irq_a_pin};

   for (genvar g = 0; g < eipc_pkg::EIPC_NUM_PINS; g++)
   begin : g_pin
      eipc_pin_sync u_sync
      (
         .sys_clk (sys_clk),
         .rst     (rst),
         .pin_i   (pin_raw[g]),
         .level   (pin_lvl[g]),
         .rise    (pin_rise[g]),
         .fall    (pin_fall[g])
      );
   end

   // byte address of each pin's control register
   function automatic logic [15:0] reg_ofs(input int idx);
      case (idx)
         0:       reg_ofs = eipc_pkg::EIPC_OFS_A;
         1:       reg_ofs = eipc_pkg::EIPC_OFS_B;
         default: reg_ofs = eipc_pkg::EIPC_OFS_C;
      endcase
   endfunction : reg_ofs

   // read image of one control register
   function automatic logic [7:0] read_ctl(input eipc_pkg::eipc_ctl_s c,
                                           input logic lvl,
                                           input logic has_gpio);
      logic [7:0] v;
      v                            = eipc_pkg::EIPC_CTRL_RESET;
      v[eipc_pkg::EIPC_FLAG_BIT]   = c.edge_seen_flag;
      v[eipc_pkg::EIPC_LEVEL_BIT]  = lvl;
      v[eipc_pkg::EIPC_DIR_BIT]    = has_gpio & c.pin_direction;
      v[eipc_pkg::EIPC_DOUT_BIT]   = has_gpio & c.pin_drive_value;
      v[eipc_pkg::EIPC_POL_BIT]    = c.edge_select;
      v[eipc_pkg::EIPC_PRI_BIT]    = c.level_select;
      v[eipc_pkg::EIPC_EN_BIT]     = c.line_enable;
      read_ctl = v;
   endfunction : read_ctl

   // trigger seen on the selected edge
   function automatic logic edge_hit(input logic pol,
                                     input logic r,
                                     input logic f);
      edge_hit = pol ? r : f;
   endfunction : edge_hit

   assign low_power = sys_ctl.halt_mode | sys_ctl.standby_mode;
   // hard watchdog in low power overrides every mask on the first pin
   assign nmi_mode  = sys_ctl.nonmaskable_select
                    | (low_power & sys_ctl.hard_watchdog);

   always_comb
   begin
      for (int i = 0; i < eipc_pkg::EIPC_NUM_PINS; i++)
      begin
         ev[i] = edge_hit(st_q.ctl[i].edge_select, pin_rise[i], pin_fall[i]);
      end
   end

   always_comb
   begin
      logic gate;
      logic req;
      logic wk;
      gate          = 1'b0;
      req           = 1'b0;
      wk            = 1'b0;
      st_d          = st_q;
      st_d.nmi_req  = nmi_mode & ev[0];
      st_d.level_one_req = 1'b0;
      st_d.level_two_req = 1'b0;
      st_d.wake_req = low_power & nmi_mode & ev[0];
      for (int i = 0; i < eipc_pkg::EIPC_NUM_PINS; i++)
      begin
         if (pf_req.wr && (pf_req.addr == reg_ofs(i)))
         begin
            st_d.ctl[i].edge_select  = pf_req.wdata[eipc_pkg::EIPC_POL_BIT];
            st_d.ctl[i].level_select = pf_req.wdata[eipc_pkg::EIPC_PRI_BIT];
            st_d.ctl[i].line_enable  = pf_req.wdata[eipc_pkg::EIPC_EN_BIT];
            if (i != 0)
            begin
               st_d.ctl[i].pin_direction   = pf_req.wdata[eipc_pkg::EIPC_DIR_BIT];
               st_d.ctl[i].pin_drive_value = pf_req.wdata[eipc_pkg::EIPC_DOUT_BIT];
            end
            if (!pf_req.wdata[eipc_pkg::EIPC_FLAG_BIT])
            begin
               st_d.ctl[i].edge_seen_flag = 1'b0;
            end
         end
         // set after clear so a coinciding edge is kept
         if (ev[i] && !((i == 0) && nmi_mode))
         begin
            st_d.ctl[i].edge_seen_flag = 1'b1;
         end
         gate = st_q.ctl[i].level_select ? sys_ctl.low_level_global_enable
                                         : sys_ctl.high_level_global_enable;
         req  = st_q.ctl[i].edge_seen_flag & st_q.ctl[i].line_enable & gate
              & !((i == 0) && nmi_mode);
         if (req && !st_q.ctl[i].level_select)
         begin
            st_d.level_one_req = 1'b1;
         end
         if (req && st_q.ctl[i].level_select)
         begin
            st_d.level_two_req = 1'b1;
         end
         // halt wakes on the active level, standby on the latched flag
         wk = sys_ctl.halt_mode
            ? (pin_lvl[i] == st_q.ctl[i].edge_select)
            : st_q.ctl[i].edge_seen_flag;
         if (low_power && wk && st_q.ctl[i].line_enable && gate
             && !((i == 0) && nmi_mode))
         begin
            st_d.wake_req = 1'b1;
         end
      end
      st_d.ctl[0].pin_direction   = 1'b0;
      st_d.ctl[0].pin_drive_value = 1'b0;
      if (pf_req.rd)
      begin
         st_d.rdata = eipc_pkg::EIPC_CTRL_RESET;
         for (int i = 0; i < eipc_pkg::EIPC_NUM_PINS; i++)
         begin
            if (pf_req.addr == reg_ofs(i))
            begin
               st_d.rdata = read_ctl(st_q.ctl[i], pin_lvl[i], i != 0);
            end
         end
      end
      // outputs follow the next register value so they come straight from flops
      st_d.gp_out[0]  = st_d.ctl[1].pin_drive_value;
      st_d.gp_out[1]  = st_d.ctl[2].pin_drive_value;
      st_d.gp_oe_n[0] = ~st_d.ctl[1].pin_direction;
      st_d.gp_oe_n[1] = ~st_d.ctl[2].pin_direction;
   end

   always_ff @(posedge sys_clk or posedge rst)
   begin
      if (rst)
      begin
         st_q         <= '0;
         st_q.ctl     <= {3{eipc_pkg::EIPC_CTL_RESET}};
         st_q.gp_oe_n <= 2'h3;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   assign pf_rdata           = st_q.rdata;
   assign level_one_req      = st_q.level_one_req;
   assign level_two_req      = st_q.level_two_req;
   assign nmi_req            = st_q.nmi_req;
   assign wake_req           = st_q.wake_req;
   assign ext_irq_b_pin_o    = st_q.gp_out[0];
   assign ext_irq_b_pin_oe_n = st_q.gp_oe_n[0];
   assign ext_irq_c_pin_o    = st_q.gp_out[1];
   assign ext_irq_c_pin_oe_n = st_q.gp_oe_n[1];

   // checks
   logic wr_b;
   logic clr_b;
   assign wr_b  = pf_req.wr && (pf_req.addr == eipc_pkg::EIPC_OFS_B);
   assign clr_b = wr_b && !pf_req.wdata[eipc_pkg::EIPC_FLAG_BIT];

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   flag_set_a : assert property (ev[1] |=> st_q.ctl[1].edge_seen_flag)
      else $error("selected edge on pin b did not set its flag");

   flag_hold_a : assert property (st_q.ctl[1].edge_seen_flag && !clr_b
                                  |=> st_q.ctl[1].edge_seen_flag)
      else $error("pin b flag dropped without a software clear");

   flag_clear_a : assert property (clr_b && !ev[1]
                                   |=> !st_q.ctl[1].edge_seen_flag)
      else $error("software clear of pin b flag was lost");

   set_wins_a : assert property (clr_b && ev[1]
                                 |=> st_q.ctl[1].edge_seen_flag)
      else $error("edge coinciding with a clear was lost");

   nmi_noflag_a : assert property (nmi_mode && !st_q.ctl[0].edge_seen_flag
                                   |=> !st_q.ctl[0].edge_seen_flag)
      else $error("pin a flag set while nonmaskable");

   nmi_pulse_a : assert property (nmi_mode && ev[0] |=> nmi_req)
      else $error("edge on nonmaskable pin a raised no request");

   nmi_cause_a : assert property (nmi_req |-> $past(nmi_mode) && $past(ev[0]))
      else $error("nonmaskable request without a pin a edge");

   lvl_one_req_a : assert property (st_q.ctl[1].edge_seen_flag && st_q.ctl[1].line_enable
                                    && !st_q.ctl[1].level_select
                                    && sys_ctl.high_level_global_enable
                                    |=> level_one_req)
      else $error("enabled pin b flag gave no level one request");

   lvl_masked_a : assert property (!sys_ctl.low_level_global_enable |=> !level_two_req)
      else $error("level two request with its global enable clear");

   gpo_drive_a : assert property (st_q.ctl[1].pin_direction
                                  |-> !ext_irq_b_pin_oe_n
                                  && ext_irq_b_pin_o == st_q.ctl[1].pin_drive_value)
      else $error("pin b output does not follow its drive value");

   level_read_a : assert property (pf_req.rd && pf_req.addr == eipc_pkg::EIPC_OFS_C
                                   |=> pf_rdata[eipc_pkg::EIPC_LEVEL_BIT]
                                       == $past(pin_lvl[2]))
      else $error("pin c level readback mismatch");

   nmi_seen_c   : cover property (nmi_mode ##1 nmi_req);
   lvl_two_c    : cover property (level_two_req);
   clr_race_c   : cover property (clr_b && ev[1]);
   wake_halt_c  : cover property (sys_ctl.halt_mode ##1 wake_req);

endmodule : eipc_ctrl

// file: eipc_pin_model.sv
// partner model: external drivers on the three interrupt pins
module eipc_pin_model
(
   input  wire logic [2:0] drv,
   input  wire logic       b_o,
   input  wire logic       b_oe_n,
   input  wire logic       c_o,
   input  wire logic       c_oe_n,
   output logic            pin_a,
   output logic            pin_b,
   output logic            pin_c
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin_a = drv[0];
   // the device owns the wire while its enable is low
   assign pin_b = b_oe_n ? drv[1] : b_o;
   assign pin_c = c_oe_n ? drv[2] : c_o;
endmodule : eipc_pin_model

// file: testbench.sv
// self-checking testbench of the external interrupt pin controller
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   sys_clk = 1'b0;
   logic                   rst = 1'b1;
   eipc_pkg::eipc_pf_req_s pf_req = '0;
   eipc_pkg::eipc_sys_s    sc = '0;
   logic [2:0]             drv = 3'h0;
   logic [7:0]             pf_rdata;
   logic                   pa, pb, pc, bo, boe, co, coe, l1, l2, nmi, wake;
   logic [7:0]             exp_q[$];
   logic [7:0]             cv;
   logic                   edg, ls, en, gh, gl;
   logic [15:0]            ad;
   int                     fail_count = 0;
   int                     comparisons = 0;
   int                     cycles = 0;
   int                     nmi_cnt = 0;
   int                     base;
   int                     p;
   integer                 seed = 32'hcf481233;

   always #25 sys_clk = ~sys_clk;

   eipc_ctrl dut (.sys_clk(sys_clk), .rst(rst), .pf_req(pf_req), .pf_rdata(pf_rdata),
      .sys_ctl(sc), .ext_irq_a_pin(pa), .ext_irq_b_pin_i(pb), .ext_irq_b_pin_o(bo),
      .ext_irq_b_pin_oe_n(boe), .ext_irq_c_pin_i(pc), .ext_irq_c_pin_o(co),
      .ext_irq_c_pin_oe_n(coe), .level_one_req(l1), .level_two_req(l2), .nmi_req(nmi),
      .wake_req(wake));

   eipc_pin_model model (.drv(drv), .b_o(bo), .b_oe_n(boe), .c_o(co), .c_oe_n(coe),
      .pin_a(pa), .pin_b(pb), .pin_c(pc));

   task cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #5;
   endtask : cyc

   task acc(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
      pf_req.addr = a;
      pf_req.wr = w;
      pf_req.rd = r;
      pf_req.wdata = d;
      cyc(1);
      pf_req.wr = 1'b0;
      pf_req.rd = 1'b0;
      cyc(1);
   endtask : acc

   task rd(input logic [15:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      acc(1'b0, 1'b1, a, 8'h00);
   endtask : rd

   task chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
         fail_count++;
      end
   endtask : chk8

   task chk_bit(input logic got, input logic exp, input string m);
      comparisons++;
      if (got !== exp)
      begin
         $display("wrong value at %0t: %s got %b expected %b", $time, m, got, exp);
         fail_count++;
      end
   endtask : chk_bit

   task conclude;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : conclude

   // read data lands on the read edge itself and is checked 1 ns later
   always @(posedge sys_clk)
   begin
      if (pf_req.rd === 1'b1)
      begin
         #1;
         chk8(pf_rdata, exp_q.pop_front(), "read data");
      end
   end

   always @(posedge sys_clk)
   begin
      if (nmi === 1'b1)
         nmi_cnt++;
      cycles++;
      if (cycles == 20000)
      begin
         fail_count++;
         $display("wrong value at %0t: run timed out", $time);
         conclude();
      end
   end

   initial
   begin
      repeat (6) @(posedge sys_clk);
      #5;
      rst = 1'b0;
      for (int i = 0; i < 3; i++)
         rd(16'h1017 + 16'(i), 8'h00);
      $display("test reset values done");
      for (int i = 0; i < 12; i++)
      begin
         p = i % 3;
         ad = 16'h1017 + 16'(p);
         {edg, ls, en, gh, gl} = 5'($random(seed));
         sc.high_level_global_enable = gh;
         sc.low_level_global_enable = gl;
         drv[p] = ~edg;
         cyc(4);
         cv = {5'h00, edg, ls, en};
         // reserved bits written high must read back low
         acc(1'b1, 1'b0, ad, cv | (p == 0 ? 8'h38 : 8'h20));
         rd(ad, cv | {1'b0, ~edg, 6'h00});
         drv[p] = edg;
         cyc(5);
         rd(ad, cv | {1'b1, edg, 6'h00});
         chk_bit(l1, en & ~ls & gh, "level one request");
         chk_bit(l2, en & ls & gl, "level two request");
         acc(1'b1, 1'b0, ad, cv);
         cyc(1);
         chk_bit(l1 | l2, 1'b0, "request after clear");
      end
      $display("test edges and requests done");
      for (int i = 1; i < 3; i++)
      begin
         ad = 16'h1017 + 16'(i);
         drv[i] = 1'b0;
         cyc(4);
         acc(1'b1, 1'b0, ad, 8'h14);
         chk_bit(i == 1 ? boe : coe, 1'b0, "output enable");
         acc(1'b1, 1'b0, ad, 8'h1C);
         cyc(4);
         chk_bit(i == 1 ? bo : co, 1'b1, "pin drive");
         rd(ad, 8'hDC);
         acc(1'b1, 1'b0, ad, 8'h00);
         chk_bit(i == 1 ? boe : coe, 1'b1, "output released");
      end
      acc(1'b1, 1'b0, 16'h101A, 8'hFF);
      rd(16'h101A, 8'h00);
      rd(16'h1016, 8'h00);
      $display("test output pins done");
      drv[0] = 1'b0;
      sc.high_level_global_enable = 1'b1;
      sc.low_level_global_enable = 1'b1;
      cyc(4);
      acc(1'b1, 1'b0, 16'h1017, 8'h05);
      sc.nonmaskable_select = 1'b1;
      base = nmi_cnt;
      repeat (3)
      begin
         drv[0] = 1'b1;
         cyc(3);
         drv[0] = 1'b0;
         cyc(3);
      end
      cyc(3);
      chk8(8'(nmi_cnt - base), 8'h03, "nonmaskable pulses");
      rd(16'h1017, 8'h05);
      chk_bit(l1 | l2, 1'b0, "masked level request");
      sc = '0;
      sc.hard_watchdog = 1'b1;
      sc.standby_mode = 1'b1;
      base = nmi_cnt;
      drv[0] = 1'b1;
      cyc(3);
      drv[0] = 1'b0;
      cyc(4);
      chk8(8'(nmi_cnt - base), 8'h01, "low power pulse");
      $display("test nonmaskable done");
      // halt wakes on the pin b level matching its selected edge
      sc = '0;
      sc.halt_mode = 1'b1;
      sc.high_level_global_enable = 1'b1;
      acc(1'b1, 1'b0, 16'h1018, 8'h05);
      chk_bit(wake, 1'b0, "no wake while pin low");
      drv[1] = 1'b1;
      cyc(4);
      chk_bit(wake, 1'b1, "halt wake on level");
      $display("test wake done");
      conclude();
   end
endmodule : testbench
